// ===== rtl/srbc_pkg.sv
// Package: register layout, field positions and reset values for the bucket config word
package srbc_pkg;
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CLASS_OFFSET = 8'h08;
  localparam logic [7:0] COUNT0_OFFSET = 8'h0C;
  localparam logic [7:0] COUNT1_OFFSET = 8'h10;
  localparam int GAP_BIT = 18;
  localparam int B1_RATE_BIT = 17;
  localparam int B1_MASK_LSB = 9;
  localparam int B0_RATE_BIT = 8;
  localparam int RSVD7_BIT = 7;
  localparam int B0_MASK_LSB = 0;
  localparam int MASK_W = 7;
  localparam logic [31:0] CFG_RESET = 32'h0001_0080;
  localparam logic [31:0] CFG_WMASK = 32'h0007_FFFF;
  localparam int CLS_UC_HIT = 0;
  localparam int CLS_MC_HIT = 1;
  localparam int CLS_RSVD_MAC = 2;
  localparam int CLS_BCAST = 3;
  localparam int CLS_MC_MISS = 4;
  localparam int CLS_UC_MISS = 5;
  localparam int CLS_RSVD = 6;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
endpackage

// ===== rtl/srbc_counter.sv
// Saturating event counter used for per-bucket charged-frame statistics
`timescale 1ns/1ps
module srbc_counter #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic clr,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_reg;
  assign count = count_reg;
  // Saturates so software never sees a wrap that looks like a quiet period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (inc) begin
      // An increment in the clear cycle wins, even when already saturated
      if (!(&count_reg)) begin
        count_reg <= count_reg + WIDTH'(1);
      end
    end else if (clr) begin
      count_reg <= '0;
    end
  end
endmodule

// ===== rtl/srbc_top.sv
// Storm suppression bucket configuration word with per-frame class steering
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Bits 15:9 hold bucket 1 class mask; set enables suppression; resets zero.
// - Bucket 1 mask bits 9..15: uc hit, mc hit, rsvd mac, bcast, mc miss, uc miss, rsvd.
// - Bit 8 clear means bucket 0 counts absolute rate; reset value clear.
// - Bit 8 set means bucket 0 rate is normalised to link speed.
// - Bit 7 reserved, resets one, software writes default, no function.
// - Bits 6:0 hold bucket 0 class mask; set enables suppression; resets zero.
// - Bucket 0 mask bits 0..6 in same class order as bucket 1.
// - Bit 18 set includes inter-packet gap in rate measurement; default excludes.
module srbc_top #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic frame_valid,
  input wire logic [6:0] frame_class,
  input wire logic bucket0_over,
  input wire logic bucket1_over,
  output logic bucket0_charge,
  output logic bucket1_charge,
  output logic frame_drop,
  output logic bucket0_rate_mode_select,
  output logic bucket1_rate_mode_select,
  output logic gap_length_include,
  output logic [6:0] bucket0_class_mask,
  output logic [6:0] bucket1_class_mask
);
  logic [31:0] cfg_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [6:0] last_class_reg;
  logic [1:0] last_hit_reg;
  logic drop_reg;
  logic clr_counts;
  logic [CNT_W-1:0] count0;
  logic [CNT_W-1:0] count1;
  logic hit0;
  logic hit1;

  // =====================================================
  // Helpers
  function automatic logic class_hit(input logic [6:0] mask, input logic [6:0] cls);
    class_hit = |(mask & cls);
  endfunction

  // =====================================================
  // Configuration word
  // Only bits 18:0 are writable; upper reserved bits hold zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= srbc_pkg::CFG_RESET;
    end else if (reg_wr && reg_addr == srbc_pkg::CFG_OFFSET) begin
      cfg_reg <= reg_wdata & srbc_pkg::CFG_WMASK;
    end
  end

  assign bucket1_class_mask = cfg_reg[srbc_pkg::B1_MASK_LSB +: srbc_pkg::MASK_W];
  assign bucket0_class_mask = cfg_reg[srbc_pkg::B0_MASK_LSB +: srbc_pkg::MASK_W];
  // Low selects absolute count, high selects link-speed normalised count
  assign bucket0_rate_mode_select = cfg_reg[srbc_pkg::B0_RATE_BIT];
  assign bucket1_rate_mode_select = cfg_reg[srbc_pkg::B1_RATE_BIT];
  assign gap_length_include = cfg_reg[srbc_pkg::GAP_BIT];
  // Bit 7 is stored for readback only and steers nothing

  // =====================================================
  // Frame steering
  // Class vector is one-hot in the order unicast hit first, reserved last;
  // the reserved class bit is masked like the others so software decides
  assign hit0 = frame_valid && class_hit(bucket0_class_mask, frame_class);
  assign hit1 = frame_valid && class_hit(bucket1_class_mask, frame_class);
  assign bucket0_charge = hit0;
  assign bucket1_charge = hit1;
  // Suppression only through a bucket that watches this class
  assign frame_drop = (hit0 && bucket0_over) || (hit1 && bucket1_over);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_class_reg <= '0;
      last_hit_reg <= '0;
      drop_reg <= 1'b0;
    end else if (frame_valid) begin
      last_class_reg <= frame_class;
      last_hit_reg <= {hit1, hit0};
      drop_reg <= frame_drop;
    end
  end

  // =====================================================
  // Statistics
  assign clr_counts = reg_rd && reg_addr == srbc_pkg::STATUS_OFFSET;

  srbc_counter #(.WIDTH(CNT_W)) u_count0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inc(hit0),
    .clr(clr_counts),
    .count(count0)
  );

  srbc_counter #(.WIDTH(CNT_W)) u_count1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inc(hit1),
    .clr(clr_counts),
    .count(count1)
  );

  // =====================================================
  // Read path
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_addr == srbc_pkg::CFG_OFFSET) begin
      rdata_next = cfg_reg;
    end else if (reg_addr == srbc_pkg::STATUS_OFFSET) begin
      rdata_next = {29'h0000_0000, drop_reg, last_hit_reg};
    end else if (reg_addr == srbc_pkg::CLASS_OFFSET) begin
      rdata_next = {25'h000_0000, last_class_reg};
    end else if (reg_addr == srbc_pkg::COUNT0_OFFSET) begin
      rdata_next = 32'(count0);
    end else if (reg_addr == srbc_pkg::COUNT1_OFFSET) begin
      rdata_next = 32'(count1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule

// ===== testbench/srbc_top_chk.sv
// Checker for the bucket config word and frame steering
`timescale 1ns/1ps
module srbc_top_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic frame_valid,
  input wire logic [6:0] frame_class,
  input wire logic bucket0_over,
  input wire logic bucket1_over,
  input wire logic bucket0_charge,
  input wire logic bucket1_charge,
  input wire logic frame_drop,
  input wire logic bucket0_rate_mode_select,
  input wire logic gap_length_include,
  input wire logic [6:0] bucket0_class_mask,
  input wire logic [6:0] bucket1_class_mask
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire cfg_wr = reg_wr && reg_addr == srbc_pkg::CFG_OFFSET;
  wire cfg_rd = reg_rd && reg_addr == srbc_pkg::CFG_OFFSET;
  property p_b1; cfg_wr |=> bucket1_class_mask == $past(reg_wdata[15:9]); endproperty
  a_b1: assert property (p_b1) else $error("mask1");
  property p_b0; cfg_wr |=> bucket0_class_mask == $past(reg_wdata[6:0]); endproperty
  a_b0: assert property (p_b0) else $error("mask0");
  property p_md; cfg_wr |=> bucket0_rate_mode_select == $past(reg_wdata[8]); endproperty
  a_md: assert property (p_md) else $error("mode");
  property p_gp; cfg_wr |=> gap_length_include == $past(reg_wdata[18]); endproperty
  a_gp: assert property (p_gp) else $error("gap");
  // Masks move only on a config write
  property p_hd; !cfg_wr |=> $stable(bucket1_class_mask) && $stable(bucket0_class_mask); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_c0; bucket0_charge == (frame_valid && |(frame_class & bucket0_class_mask)); endproperty
  a_c0: assert property (p_c0) else $error("chg0");
  property p_c1; bucket1_charge == (frame_valid && |(frame_class & bucket1_class_mask)); endproperty
  a_c1: assert property (p_c1) else $error("chg1");
  property p_rd; cfg_rd |=> reg_rdata[15:9] == bucket1_class_mask; endproperty
  a_rd: assert property (p_rd) else $error("read");
  // Suppression only through a bucket that watches the frame's class
  property p_dp;
    frame_drop == (frame_valid && (|(frame_class & bucket0_class_mask) && bucket0_over ||
      |(frame_class & bucket1_class_mask) && bucket1_over));
  endproperty
  a_dp: assert property (p_dp) else $error("drop");
endmodule
bind srbc_top srbc_top_chk i_srbc_top_chk (.*);

// ===== testbench/srbc_top_tb.sv
// Random and corner-case bench for the bucket config word
`timescale 1ns/1ps
module srbc_top_tb;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, frame_valid = 0;
  logic bucket0_over = 0, bucket1_over = 0, bucket0_charge, bucket1_charge, frame_drop;
  logic bucket0_rate_mode_select, bucket1_rate_mode_select, gap_length_include;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
  logic [6:0] frame_class = 7'h00, bucket0_class_mask, bucket1_class_mask;
  integer error_cnt = 0, n_checks = 0, seed = 32'h95e1_70b1;
  integer c0 = 0, c1 = 0;
  logic [2:0] last_st = 3'h0;
  srbc_top i_srbc_top (.*);
  always #2.5 sys_clk = ~sys_clk;
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Expected {drop, charge1, charge0} for a one-hot class k under config word v
  function automatic logic [2:0] exp_frm(input logic [31:0] v, input int k,
    input logic o1, input logic o0);
    exp_frm = {v[k] & o0 | v[9+k] & o1, v[9+k], v[k]};
  endfunction
  // Config pins as the rules place them in the word
  function automatic logic [31:0] pins_of(input logic [31:0] v);
    pins_of = {15'h0000, v[18:17], v[8], v[15:9], v[6:0]};
  endfunction
  task chk_frm(input logic [2:0] g, input logic [2:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t frame got %b exp %b", $time, g, e);
    end
  endtask
  task chk_pins(input logic [31:0] v);
    logic [31:0] g;
    g = {15'h0000, gap_length_include, bucket1_rate_mode_select, bucket0_rate_mode_select,
      bucket1_class_mask, bucket0_class_mask};
    n_checks++;
    if (g !== pins_of(v)) begin
      error_cnt++;
      $display("[ERR] %0t pins got %h exp %h", $time, g, pins_of(v));
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0001_0080);
    chk_pins(32'h0001_0080);
    for (int i = 0; i < 24; i++) begin
      // Software keeps the reserved bits at default
      d = (i < 2) ? {13'h0000, {19{i[0]}}} : $random(seed) & 32'h0007_FFFF;
      d = d | 32'h0001_0080;
      wr(8'h00, d);
      rd(8'h00, d);
      chk_pins(d);
      for (int k = 0; k < 7; k++) begin
        @(posedge sys_clk);
        frame_valid <= 1'b1;
        frame_class <= 7'h01 << k;
        {bucket1_over, bucket0_over} <= 2'($random(seed));
        #1 chk_frm({frame_drop, bucket1_charge, bucket0_charge},
          exp_frm(d, k, bucket1_over, bucket0_over));
        c0 = c0 + d[k];
        c1 = c1 + d[9+k];
        last_st = exp_frm(d, k, bucket1_over, bucket0_over);
      end
      @(posedge sys_clk);
      frame_valid <= 1'b0;
    end
    wr(8'h20, 32'h0000_0000);
    rd(8'h00, d);
    rd(8'h20, 32'h0000_0000);
    // Last frame of the loop carried the top class bit
    rd(srbc_pkg::CLASS_OFFSET, 32'h0000_0040);
    rd(srbc_pkg::COUNT0_OFFSET, 32'(c0));
    rd(srbc_pkg::COUNT1_OFFSET, 32'(c1));
    rd(srbc_pkg::STATUS_OFFSET, {29'h0000_0000, last_st});
    // The status read has cleared both counters
    rd(srbc_pkg::COUNT0_OFFSET, 32'h0000_0000);
    rd(srbc_pkg::COUNT1_OFFSET, 32'h0000_0000);
    stop_test;
  end
endmodule
